//--- src/seq_wait_defines.svh
// register map, field positions, reset values and command codes of the wait and step-delay block
`ifndef SEQ_WAIT_DEFINES_SVH
`define SEQ_WAIT_DEFINES_SVH

`define OFS_CTRL_STAT 8'h00
`define OFS_TMR0_LIM 8'h04
`define OFS_TMR1_LIM 8'h08
`define OFS_STEP_DELAY_TIMER_LIM 8'h0C
`define OFS_WDOG_LIM 8'h10

`define BIT_ENABLE 0
`define BIT_RUN 1
`define BIT_SOFT_TRIG 2
`define BIT_VISIBLE 3
`define BIT_ITM_LO 4
`define BIT_ITM_HI 5
`define BIT_WDTO 6
`define BIT_STEP_DELAY_TIMER_ON 7
`define BIT_BUSY 8

`define LIM_RESET 16'h0000

`define FLD_CTRL 4'h0
`define FLD_WAIT_HIGH 4'h4
`define FLD_WAIT_LOW 4'h5

`define OPT_STEP_DELAY_TIMER_OFF 4'h2
`define OPT_STEP_DELAY_TIMER_ON 4'h6
`define OPT_WAIT_TMR0 4'h8
`define OPT_WAIT_TMR1 4'h9
`define OPT_SOFT_LEVEL 4'hA
`define OPT_SOFT_EDGE 4'hB

`define SEL_TMR0 2'h0
`define SEL_TMR1 2'h1
`define SEL_STEP_DELAY_TIMER 2'h2

`endif

//--- src/seq_wait_pkg.sv
// types shared by the wait and step-delay block
package seq_wait_pkg;

  typedef struct packed {
    logic [3:0] field;
    logic [3:0] option;
  } cmd_s;

  typedef struct packed {
    logic [1:0] sel;
    logic [15:0] data;
  } lim_load_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DELAY = 2'b10
  } state_e;

endpackage

//--- src/sequencer_wait_and_step_delay.sv
// trigger sequencer wait conditions, general timers and step delay with an apb register port
//
// Behaviour
// [RULE1] sixteen trigger inputs; wait-high wants rise or high, wait-low fall or low
// [RULE2] a trigger wait repeats until met; at least one clock, bounded only by watchdog
// [RULE3] mode 0: edge watched from wait start; on hit complete, then one step delay
// [RULE4] edge catchers clear at completion before delay; only wait or prior delay edges count
// [RULE5] mode 1: edges as mode 0, never a step delay at exit
// [RULE6] mode 2: level sampled each clock, failed test retested after step delay, delay at exit
// [RULE7] mode 3: like mode 2 but next command starts at once on success
// [RULE8] level modes without step delay retest next clock and exit at once
// [RULE9] level modes never latch: level true at start passes, absent level ignored
// [RULE10] software edge wait completes only on a 0-to-1 of the bit during the wait
// [RULE11] software edge wait clears the software trigger bit on completion
// [RULE12] software level wait passes while the bit is 1 and leaves it set
// [RULE13] two 16-bit up timers with limits, cleared in reset and while disabled
// [RULE14] limits written by software only when disabled, by commands when enabled; read per visibility
// [RULE15] timer wait counts until timer equals limit, then completes and clears that timer
// [RULE16] step delay off after reset; option 0110 turns it on, 0010 off
// [RULE17] step delay counts clocks after each command until limit; cleared during every command
// [RULE18] delay limit 0 adds nothing, limit 1 adds exactly one clock
// [RULE19] edge catchers reset per command; edges in an edge wait's exit delay are not carried forward; a watchdog abort does not clear them
// [RULE20] disabling aborts waits and delays at once; other commands finish
// [RULE21] hardware wait past watchdog: abort, halt, set timeout flag, pulse error interrupt
// [RULE22] a non-waiting, undelayed command takes one clock
// [RULE23] hardware waits pick their input from the 4-bit option field
`include "seq_wait_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sequencer_wait_and_step_delay #(
  parameter int NUM_TRIG = 16,
  parameter int TMR_W = 16
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NUM_TRIG-1:0] TRIG_IN,
  input wire logic CMD_VALID,
  input wire seq_wait_pkg::cmd_s CMD_CODE,
  output logic CMD_READY,
  output logic CMD_DONE,
  input wire logic LIM_LOAD_VALID,
  input wire seq_wait_pkg::lim_load_s LIM_LOAD,
  output logic WDT_IRQ
);

  seq_wait_pkg::state_e state_q, state_d;
  seq_wait_pkg::cmd_s cmd_q;
  logic en_q, run_q, swt_q, vis_q, wdto_q, sd_en_q, swt_prev_q;
  logic [1:0] itm_q;
  logic [TMR_W-1:0] t0_q, t1_q, t0_lim_q, t1_lim_q, sd_cnt_q, sd_lim_q, wdt_cnt_q, wdt_lim_q;
  logic [NUM_TRIG-1:0] trig_prev_q, rise_q, fall_q;
  logic retest_q, no_arm_q;

  // decode of the command in execution
  logic is_hw, is_sw_edge, is_sw_level, is_tmr0, is_tmr1, is_wait, pol_high, sel_level;
  logic armed, met, sd_active, exit_delay, level_fail, wdt_fire, accept, leave_exec, sd_end;
  logic [NUM_TRIG-1:0] rise_now, fall_now;
  logic [3:0] sel;

  assign sel = cmd_q.option; // RULE23
  assign is_hw = (cmd_q.field == `FLD_WAIT_HIGH) || (cmd_q.field == `FLD_WAIT_LOW);
  assign pol_high = (cmd_q.field == `FLD_WAIT_HIGH); // RULE1
  assign is_sw_edge = (cmd_q.field == `FLD_CTRL) && (cmd_q.option == `OPT_SOFT_EDGE);
  assign is_sw_level = (cmd_q.field == `FLD_CTRL) && (cmd_q.option == `OPT_SOFT_LEVEL);
  assign is_tmr0 = (cmd_q.field == `FLD_CTRL) && (cmd_q.option == `OPT_WAIT_TMR0);
  assign is_tmr1 = (cmd_q.field == `FLD_CTRL) && (cmd_q.option == `OPT_WAIT_TMR1);
  assign is_wait = is_hw || is_sw_edge || is_sw_level || is_tmr0 || is_tmr1;
  assign sel_level = itm_q[1];
  assign sd_active = sd_en_q && (sd_lim_q != `LIM_RESET); // RULE18
  assign accept = CMD_VALID && CMD_READY;

  // edges count during a wait and during the prior command's delay, not after an edge wait
  assign armed = (state_q == seq_wait_pkg::ST_EXEC) || ((state_q == seq_wait_pkg::ST_DELAY) && !no_arm_q); // RULE4 RULE19
  assign rise_now = TRIG_IN & ~trig_prev_q & {NUM_TRIG{armed}};
  assign fall_now = ~TRIG_IN & trig_prev_q & {NUM_TRIG{armed}};

  always_comb begin
    met = 1'b1; // RULE22
    level_fail = 1'b0;
    if (is_hw && !sel_level) begin
      met = pol_high ? (rise_q[sel] | rise_now[sel]) : (fall_q[sel] | fall_now[sel]); // RULE3 RULE5
    end else if (is_hw) begin
      met = (TRIG_IN[sel] == pol_high); // RULE9
      level_fail = !met;
    end else if (is_sw_edge) begin
      met = swt_q && !swt_prev_q; // RULE10
    end else if (is_sw_level) begin
      met = swt_q; // RULE12
    end else if (is_tmr0) begin
      met = (t0_q == t0_lim_q); // RULE15
    end else if (is_tmr1) begin
      met = (t1_q == t1_lim_q); // RULE15
    end
  end

  // modes 1 and 3 never add an exit delay
  assign exit_delay = sd_active && !(is_hw && itm_q[0]); // RULE3 RULE5 RULE6 RULE7
  assign wdt_fire = (state_q == seq_wait_pkg::ST_EXEC) && is_hw && en_q && !met
                    && (wdt_lim_q != `LIM_RESET) && (wdt_cnt_q >= wdt_lim_q - 16'h0001); // RULE21
  assign leave_exec = (state_q == seq_wait_pkg::ST_EXEC) && met && !(is_wait && !en_q) && !wdt_fire;
  assign sd_end = (sd_cnt_q + 16'h0001) == sd_lim_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      seq_wait_pkg::ST_IDLE: begin
        if (accept) begin
          state_d = seq_wait_pkg::ST_EXEC; // RULE2
        end
      end
      seq_wait_pkg::ST_EXEC: begin
        if (is_wait && !en_q) begin
          state_d = seq_wait_pkg::ST_IDLE; // RULE20
        end else if (wdt_fire) begin
          state_d = seq_wait_pkg::ST_IDLE; // RULE21
        end else if (met) begin
          state_d = exit_delay ? seq_wait_pkg::ST_DELAY : seq_wait_pkg::ST_IDLE; // RULE17
        end else if (level_fail && sd_active) begin
          state_d = seq_wait_pkg::ST_DELAY; // RULE6 RULE7
        end else begin
          state_d = seq_wait_pkg::ST_EXEC; // RULE8
        end
      end
      seq_wait_pkg::ST_DELAY: begin
        if (!en_q) begin
          state_d = seq_wait_pkg::ST_IDLE; // RULE20
        end else if (sd_end) begin
          state_d = retest_q ? seq_wait_pkg::ST_EXEC : seq_wait_pkg::ST_IDLE; // RULE6
        end
      end
      default: begin
        state_d = seq_wait_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_q <= seq_wait_pkg::ST_IDLE;
      cmd_q <= '0;
      retest_q <= 1'b0;
      no_arm_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        cmd_q <= CMD_CODE;
      end
      if (state_q == seq_wait_pkg::ST_EXEC && state_d == seq_wait_pkg::ST_DELAY) begin
        retest_q <= !met;
        no_arm_q <= met && is_hw && !sel_level; // RULE19
      end
    end
  end

  // handshake and completion strobes, all registered
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      CMD_READY <= 1'b0;
      CMD_DONE <= 1'b0;
      WDT_IRQ <= 1'b0;
    end else begin
      CMD_READY <= (state_d == seq_wait_pkg::ST_IDLE) && en_q && run_q && !accept && !wdt_fire;
      CMD_DONE <= leave_exec && !exit_delay
                  || (state_q == seq_wait_pkg::ST_DELAY && en_q && sd_end && !retest_q);
      WDT_IRQ <= wdt_fire; // RULE21
    end
  end

  // edge catchers; cleared when the command completes, ahead of any delay
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      trig_prev_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      trig_prev_q <= TRIG_IN;
      if (leave_exec || !en_q) begin
        rise_q <= '0; // RULE4 RULE19
        fall_q <= '0;
      end else begin
        rise_q <= rise_q | rise_now;
        fall_q <= fall_q | fall_now;
      end
    end
  end

  // step delay counter and its enable
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sd_en_q <= 1'b0; // RULE16
      sd_cnt_q <= '0;
    end else begin
      if (state_q == seq_wait_pkg::ST_DELAY && en_q && !sd_end) begin
        sd_cnt_q <= sd_cnt_q + 16'h0001; // RULE17
      end else begin
        sd_cnt_q <= '0; // RULE17
      end
      if (state_q == seq_wait_pkg::ST_EXEC && cmd_q.field == `FLD_CTRL) begin
        if (cmd_q.option == `OPT_STEP_DELAY_TIMER_ON) begin
          sd_en_q <= 1'b1; // RULE16
        end else if (cmd_q.option == `OPT_STEP_DELAY_TIMER_OFF) begin
          sd_en_q <= 1'b0; // RULE16
        end
      end
    end
  end

  // general timers run only while their wait executes
  always_ff @(posedge CLK) begin
    if (!RESET_N || !en_q) begin
      t0_q <= '0; // RULE13
      t1_q <= '0;
    end else begin
      if (state_q == seq_wait_pkg::ST_EXEC && is_tmr0) begin
        t0_q <= met ? '0 : t0_q + 16'h0001; // RULE15
      end
      if (state_q == seq_wait_pkg::ST_EXEC && is_tmr1) begin
        t1_q <= met ? '0 : t1_q + 16'h0001; // RULE15
      end
    end
  end

  // watchdog covers hardware waits only, stops before the exit delay
  // retest delays of a level wait still count, or a failing level wait could hang
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wdt_cnt_q <= '0;
    end else if (is_hw && (state_q == seq_wait_pkg::ST_EXEC && !met
                           || state_q == seq_wait_pkg::ST_DELAY && retest_q)) begin // RULE21
      wdt_cnt_q <= wdt_cnt_q + 16'h0001;
    end else begin
      wdt_cnt_q <= '0;
    end
  end

  // apb slave: one wait state, effect and read data at the pready edge
  logic acc, wr, rd_ok, slverr_d;
  logic [31:0] rd_data;
  assign acc = PSEL && PENABLE && PREADY;
  assign slverr_d = !rd_ok;
  assign wr = acc && PWRITE && !slverr_d;

  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (PADDR)
      `OFS_CTRL_STAT: begin
        rd_data[`BIT_ENABLE] = en_q;
        rd_data[`BIT_RUN] = run_q;
        rd_data[`BIT_SOFT_TRIG] = swt_q;
        rd_data[`BIT_VISIBLE] = vis_q;
        rd_data[`BIT_ITM_HI:`BIT_ITM_LO] = itm_q;
        rd_data[`BIT_WDTO] = wdto_q;
        rd_data[`BIT_STEP_DELAY_TIMER_ON] = sd_en_q;
        rd_data[`BIT_BUSY] = (state_q != seq_wait_pkg::ST_IDLE);
      end
      `OFS_TMR0_LIM: rd_data[15:0] = (vis_q && en_q) ? t0_q : t0_lim_q; // RULE14
      `OFS_TMR1_LIM: rd_data[15:0] = (vis_q && en_q) ? t1_q : t1_lim_q; // RULE14
      `OFS_STEP_DELAY_TIMER_LIM: rd_data[15:0] = (vis_q && en_q) ? sd_cnt_q : sd_lim_q;
      `OFS_WDOG_LIM: rd_data[15:0] = (vis_q && en_q) ? wdt_cnt_q : wdt_lim_q;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && slverr_d;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        PRDATA <= rd_data;
      end
    end
  end

  // control and status bits
  logic wr_ctrl;
  assign wr_ctrl = wr && (PADDR == `OFS_CTRL_STAT);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      en_q <= 1'b0;
      run_q <= 1'b0;
      swt_q <= 1'b0;
      vis_q <= 1'b0;
      itm_q <= 2'b00;
      wdto_q <= 1'b0;
      swt_prev_q <= 1'b0;
    end else begin
      swt_prev_q <= swt_q;
      if (wr_ctrl) begin
        en_q <= PWDATA[`BIT_ENABLE];
        run_q <= PWDATA[`BIT_RUN];
        vis_q <= PWDATA[`BIT_VISIBLE];
        itm_q <= PWDATA[`BIT_ITM_HI:`BIT_ITM_LO];
        wdto_q <= PWDATA[`BIT_WDTO];
      end
      if (wr_ctrl && PWDATA[`BIT_SOFT_TRIG]) begin
        swt_q <= 1'b1; // set beats the completion clear
      end else if (wr_ctrl || (leave_exec && is_sw_edge)) begin
        swt_q <= 1'b0; // RULE11
      end
      if (wdt_fire) begin
        run_q <= 1'b0; // RULE21
        wdto_q <= 1'b1; // RULE21
      end
      if (!en_q && !(wr_ctrl && PWDATA[`BIT_ENABLE])) begin
        run_q <= 1'b0;
        wdto_q <= 1'b0;
        swt_q <= 1'b0;
      end
    end
  end

  // limits: software while disabled, sequencer load port while enabled, except the watchdog limit which is software only
  logic sw_lim_wr;
  assign sw_lim_wr = wr && !en_q; // RULE14

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      t0_lim_q <= `LIM_RESET;
      t1_lim_q <= `LIM_RESET;
      sd_lim_q <= `LIM_RESET;
      wdt_lim_q <= `LIM_RESET;
    end else begin
      if (sw_lim_wr && PADDR == `OFS_TMR0_LIM || en_q && LIM_LOAD_VALID && LIM_LOAD.sel == `SEL_TMR0) begin
        t0_lim_q <= en_q ? LIM_LOAD.data : PWDATA[15:0]; // RULE14
      end
      if (sw_lim_wr && PADDR == `OFS_TMR1_LIM || en_q && LIM_LOAD_VALID && LIM_LOAD.sel == `SEL_TMR1) begin
        t1_lim_q <= en_q ? LIM_LOAD.data : PWDATA[15:0]; // RULE14
      end
      if (sw_lim_wr && PADDR == `OFS_STEP_DELAY_TIMER_LIM || en_q && LIM_LOAD_VALID && LIM_LOAD.sel == `SEL_STEP_DELAY_TIMER) begin
        sd_lim_q <= en_q ? LIM_LOAD.data : PWDATA[15:0];
      end
      if (sw_lim_wr && PADDR == `OFS_WDOG_LIM) begin
        wdt_lim_q <= PWDATA[15:0];
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  property p_accept_exec;
    accept |=> state_q == seq_wait_pkg::ST_EXEC;
  endproperty
  a_accept_exec: assert property (p_accept_exec) else $error("accepted command did not execute"); // RULE2

  property p_single_cycle;
    state_q == seq_wait_pkg::ST_EXEC && !is_wait && !sd_active |=> state_q == seq_wait_pkg::ST_IDLE && CMD_DONE;
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("plain command took more than one clock"); // RULE22

  property p_no_exit_delay;
    state_q == seq_wait_pkg::ST_EXEC && is_hw && itm_q[0] && met && en_q && !wdt_fire
      |=> state_q == seq_wait_pkg::ST_IDLE;
  endproperty
  a_no_exit_delay: assert property (p_no_exit_delay) else $error("exit delay inserted in mode 1 or 3"); // RULE5

  property p_level_now;
    state_q == seq_wait_pkg::ST_EXEC && is_hw && sel_level && en_q && TRIG_IN[sel] == pol_high
      |=> state_q != seq_wait_pkg::ST_EXEC;
  endproperty
  a_level_now: assert property (p_level_now) else $error("true level did not satisfy the wait"); // RULE9

  property p_soft_edge_clear;
    state_q == seq_wait_pkg::ST_EXEC && is_sw_edge && met && en_q && !wr_ctrl |=> !swt_q;
  endproperty
  a_soft_edge_clear: assert property (p_soft_edge_clear) else $error("soft trigger bit not cleared"); // RULE11

  property p_delay_one;
    $rose(state_q == seq_wait_pkg::ST_DELAY) && sd_lim_q == 16'h0001 && en_q
      |=> state_q != seq_wait_pkg::ST_DELAY;
  endproperty
  a_delay_one: assert property (p_delay_one) else $error("limit one did not add exactly one clock"); // RULE18

  property p_delay_zero;
    $rose(state_q == seq_wait_pkg::ST_DELAY) |-> $past(sd_lim_q) != `LIM_RESET;
  endproperty
  a_delay_zero: assert property (p_delay_zero) else $error("delay entered with zero limit"); // RULE18

  property p_abort;
    !en_q && is_wait && state_q == seq_wait_pkg::ST_EXEC |=> state_q == seq_wait_pkg::ST_IDLE && !CMD_DONE;
  endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort the wait"); // RULE20

  property p_timer_clear;
    state_q == seq_wait_pkg::ST_EXEC && is_tmr0 && en_q && t0_q == t0_lim_q
      |=> t0_q == '0 && state_q != seq_wait_pkg::ST_EXEC;
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer wait did not finish and clear"); // RULE15

  property p_wdt;
    wdt_fire |=> wdto_q && !run_q && WDT_IRQ && state_q == seq_wait_pkg::ST_IDLE;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog expiry not handled"); // RULE21

  property p_lim_locked;
    en_q && !LIM_LOAD_VALID |=> $stable(t0_lim_q) && $stable(t1_lim_q);
  endproperty
  a_lim_locked: assert property (p_lim_locked) else $error("timer limit changed by software while enabled"); // RULE14

endmodule

`default_nettype wire

//--- tb/trig_source.sv
// trigger source model: levels on the sixteen hardware trigger inputs
`timescale 1ns/1ps
`default_nettype none

module trig_source (
  input wire logic CLK,
  output logic [15:0] TRIG
);
  logic [15:0] lvl_q = 16'h0000;

  assign TRIG = lvl_q;

  // levels move just after an edge so the block always sees a settled synchronous input
  task automatic drive(input int idx, input logic v);
    @(posedge CLK);
    lvl_q[idx] <= v;
  endtask
endmodule

`default_nettype wire

//--- tb/sequencer_wait_and_step_delay_test.sv
// self-checking bench for the wait and step-delay block
`include "seq_wait_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sequencer_wait_and_step_delay_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] trig;
  logic cmd_valid = 1'b0;
  seq_wait_pkg::cmd_s cmd_code = 8'h00;
  logic cmd_ready;
  logic cmd_done;
  logic lim_valid = 1'b0;
  seq_wait_pkg::lim_load_s lim_load = 18'h0_0000;
  logic wdt_irq;
  int err_total = 0;
  int cmp_count = 0;
  logic [31:0] rv;
  logic se;
  int n;
  int n0;
  int n1;
  localparam logic [7:0] NOP = {`FLD_CTRL, 4'hF};
  localparam logic [7:0] SD_ON = {`FLD_CTRL, `OPT_STEP_DELAY_TIMER_ON};
  localparam logic [7:0] SD_OFF = {`FLD_CTRL, `OPT_STEP_DELAY_TIMER_OFF};

  always #5 clk = ~clk;

  sequencer_wait_and_step_delay dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TRIG_IN(trig), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_READY(cmd_ready), .CMD_DONE(cmd_done),
    .LIM_LOAD_VALID(lim_valid), .LIM_LOAD(lim_load), .WDT_IRQ(wdt_irq));

  trig_source src (.CLK(clk), .TRIG(trig));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic stop(input string s);
    err_total++;
    $display("timeout waiting for %s", s);
    close_out();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bus transfer; read data and error are taken at the edge that samples pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (pready !== 1'b1) stop("apb");
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic issue(input logic [7:0] c);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 40);
    if (cmd_ready !== 1'b1) stop("command");
    cmd_valid <= 1'b0;
  endtask

  // edges from the taking edge to the done pulse; lim+1 means it never came
  task automatic wait_done(input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (cmd_done !== 1'b1 && k <= lim);
  endtask

  task automatic run(input logic [7:0] c, input int e);
    issue(c);
    wait_done(60, n);
    chk("cycles", e, n);
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(posedge clk);
    if (cmd_ready !== 1'b1) stop("ready");
  endtask

  task automatic lim(input logic [1:0] s, input logic [15:0] d);
    @(posedge clk);
    lim_valid <= 1'b1;
    lim_load <= {s, d};
    @(posedge clk);
    lim_valid <= 1'b0;
  endtask

  task automatic edge_wait(input logic [31:0] c, input logic [7:0] code, input logic v, output int k);
    apb(1'b1, `OFS_CTRL_STAT, c);
    issue(code);
    src.drive(6, v);
    wait_done(40, k);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, `OFS_TMR0_LIM, 32'h0000_0000);
    chk("tmr0 lim", 32'h0000_0000, rv);
    apb(1'b0, `OFS_STEP_DELAY_TIMER_LIM, 32'h0000_0000);
    chk("step_delay_timer lim", 32'h0000_0000, rv);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(se));
    apb(1'b1, `OFS_TMR0_LIM, 32'h0000_0003);
    apb(1'b1, `OFS_WDOG_LIM, 32'h0000_0028);
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0003);
    wait_ready();
    // software write while enabled must not reach the limit
    apb(1'b1, `OFS_TMR0_LIM, 32'h0000_0007);
    apb(1'b0, `OFS_TMR0_LIM, 32'h0000_0000);
    chk("tmr0 lim", 32'h0000_0003, rv);
    run(NOP, 2);
    run({`FLD_CTRL, `OPT_WAIT_TMR0}, 5);
    run({`FLD_CTRL, `OPT_WAIT_TMR0}, 5);
    lim(`SEL_TMR1, 16'h0005);
    run({`FLD_CTRL, `OPT_WAIT_TMR1}, 7);
    lim(`SEL_STEP_DELAY_TIMER, 16'h0001);
    run(SD_ON, 2);
    run(NOP, 3);
    apb(1'b0, `OFS_CTRL_STAT, 32'h0000_0000);
    chk("step_delay_timer on", 32'h0000_0001, 32'(rv[`BIT_STEP_DELAY_TIMER_ON]));
    lim(`SEL_STEP_DELAY_TIMER, 16'h0000);
    run(NOP, 2);
    lim(`SEL_STEP_DELAY_TIMER, 16'h0002);
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0033);
    for (int i = 0; i < 16; i++) begin
      src.drive(i, 1'b1);
      run({`FLD_WAIT_HIGH, 4'(i)}, 2);
      src.drive(i, 1'b0);
    end
    src.drive(5, 1'b1);
    run({`FLD_WAIT_HIGH, 4'h5}, 2);
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0023);
    run({`FLD_WAIT_HIGH, 4'h5}, 4);
    issue({`FLD_WAIT_LOW, 4'h5});
    wait_done(8, n);
    chk("level held off", 9, n);
    src.drive(5, 1'b0);
    wait_done(40, n);
    chk("level seen", 1, 32'(n <= 40));
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0003);
    // edge raised while idle is not armed, so the wait must stall
    src.drive(6, 1'b1);
    issue({`FLD_WAIT_HIGH, 4'h6});
    wait_done(8, n);
    chk("stale edge", 9, n);
    src.drive(6, 1'b0);
    src.drive(6, 1'b1);
    wait_done(40, n);
    chk("fresh edge", 1, 32'(n <= 40));
    edge_wait(32'h0000_0013, {`FLD_WAIT_LOW, 4'h6}, 1'b0, n1);
    edge_wait(32'h0000_0003, {`FLD_WAIT_HIGH, 4'h6}, 1'b1, n0);
    chk("no exit delay", 2, n1);
    chk("exit delay", 4, n0);
    run(SD_OFF, 4);
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0007);
    run({`FLD_CTRL, `OPT_SOFT_LEVEL}, 2);
    apb(1'b0, `OFS_CTRL_STAT, 32'h0000_0000);
    chk("soft kept", 32'h0000_0001, 32'(rv[`BIT_SOFT_TRIG]));
    issue({`FLD_CTRL, `OPT_SOFT_EDGE});
    wait_done(8, n);
    chk("soft no edge", 9, n);
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0003);
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0007);
    wait_done(40, n);
    chk("soft edge", 1, 32'(n <= 40));
    apb(1'b0, `OFS_CTRL_STAT, 32'h0000_0000);
    chk("soft cleared", 32'h0000_0000, 32'(rv[`BIT_SOFT_TRIG]));
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0033);
    issue({`FLD_WAIT_HIGH, 4'h9});
    wait_done(5, n);
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0000);
    wait_done(20, n);
    chk("aborted", 21, n);
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0003);
    wait_ready();
    issue({`FLD_WAIT_HIGH, 4'h9});
    n = 0;
    while (wdt_irq !== 1'b1 && cmd_done !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("wdt irq", 32'h0000_0001, 32'(wdt_irq));
    chk("wdt time", 1, 32'(n >= 40 && n <= 44));
    apb(1'b0, `OFS_CTRL_STAT, 32'h0000_0000);
    chk("wdt flag", 32'h0000_0001, 32'(rv[`BIT_WDTO]));
    chk("halted", 32'h0000_0000, 32'(rv[`BIT_RUN]));
    // visibility on while enabled: the limit address shows the cleared timer
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0049);
    apb(1'b0, `OFS_TMR1_LIM, 32'h0000_0000);
    chk("tmr1 count", 32'h0000_0000, rv);
    apb(1'b1, `OFS_CTRL_STAT, 32'h0000_0000);
    apb(1'b0, `OFS_CTRL_STAT, 32'h0000_0000);
    chk("flag off", 32'h0000_0000, 32'(rv[`BIT_WDTO]));
    apb(1'b0, `OFS_TMR1_LIM, 32'h0000_0000);
    chk("tmr1 lim kept", 32'h0000_0005, rv);
    close_out();
  end
endmodule

`default_nettype wire
